// ---- hw/contact_consts.svh ----
`ifndef CONTACT_CONSTS_SVH
`define CONTACT_CONSTS_SVH
// Register byte offsets, one block of 0x20 per contact
`define REG_OP_TYPE 8'h00
`define REG_FUNC_SEL 8'h04
`define REG_TIMER_TGT 8'h08
`define REG_ASSIGN 8'h0C
`define REG_POLARITY 8'h10
`define REG_STATUS 8'h14
`define REG_CONTACT_STRIDE 8'h20
`define REG_SUMMARY 8'h60
// Reset values
`define RST_OP_TYPE 5'h00
`define RST_FUNC_SEL 3'h0
`define RST_TIMER_TGT 3'h0
`define RST_POLARITY 5'h00
`define RST_ASSIGN_C1 24'h000002
`define RST_ASSIGN_C2 24'h000003
`define RST_ASSIGN_C3 24'h000004
// Operation type codes
`define OP_LSP_W1 5'd1
`define OP_LSP_W2 5'd2
`define OP_LSP_W4 5'd3
`define OP_RUN_READY 5'd7
`define OP_AUTO_MANUAL 5'd8
`define OP_AUTO_TUNE 5'd10
`define OP_SELF_TUNE 5'd11
`define OP_REVERSE 5'd12
`define OP_RAMP 5'd13
`define OP_PV_HOLD 5'd14
`define OP_MAX_HOLD 5'd15
`define OP_MIN_HOLD 5'd16
`define OP_TIMER 5'd17
`define OP_LATCH_REL 5'd18
`define OP_MAX 5'd20
`define FUNC_MAX 3'd4
`define TGT_MAX 3'd5
// Input source codes
`define SRC_OFF 6'd0
`define SRC_ON 6'd1
`define SRC_DI1 6'd2
`define SRC_DI2 6'd3
`define SRC_EV1 6'd10
`define SRC_EV5 6'd14
`define SRC_COM1 6'd18
`define SRC_COM4 6'd21
`define SRC_MANUAL 6'd22
`define SRC_READY 6'd23
`define SRC_AT_RUN 6'd25
`define SRC_RAMPING 6'd26
`define SRC_ALARM 6'd28
`define SRC_PV_ALARM 6'd29
`define SRC_MODE_KEY 6'd31
`define SRC_EVOUT1 6'd32
`define SRC_CTRLOUT1 6'd33
`endif

// ---- hw/contact_pkg.sv ----
`default_nettype none
package contact_pkg;
  typedef struct packed {
    logic [1:0] digital_input;
    logic [4:0] internal_event;
    logic [3:0] comm_input;
    logic manual_mode;
    logic ready_mode;
    logic at_running;
    logic sp_ramping;
    logic alarm;
    logic pv_alarm;
    logic mode_key;
    logic event_out1;
    logic ctrl_out1;
  } source_bits_t;
  typedef struct packed {
    logic [5:0] sel_d;
    logic [5:0] sel_c;
    logic [5:0] sel_b;
    logic [5:0] sel_a;
  } assign_t;
  typedef struct packed {
    logic [3:0] lsp_group;
    logic ready;
    logic manual;
    logic at_start;
    logic st_enable;
    logic reverse_action;
    logic ramp_disable;
    logic pv_hold;
    logic max_hold;
    logic min_hold;
    logic [4:0] timer_run;
    logic [4:0] timer_stop;
    logic latch_release;
  } actions_t;
endpackage
`default_nettype wire

// ---- hw/contact_eval.sv ----
`include "contact_consts.svh"
`default_nettype none
module contact_eval
  import contact_pkg::*;
#(
  parameter int unsigned INDEX = 0
) (
  input wire source_bits_t src_in, // Synchronised source bits
  input wire assign_t assign_in, // Source codes A to D
  input wire logic [4:0] polarity_in, // Bits 3:0 A..D, bit 4 result
  input wire logic [2:0] func_in, // Input bit function select
  output logic state_out // Contact state, 1 is ON
);
  // Source picked by one code
  function automatic logic pick(input source_bits_t s, input logic [5:0] c);
    logic r;
    r = 1'b0;
    case (c)
      `SRC_ON: r = 1'b1;
      `SRC_DI1: r = s.digital_input[0];
      `SRC_DI2: r = s.digital_input[1];
      `SRC_MANUAL: r = s.manual_mode;
      `SRC_READY: r = s.ready_mode;
      `SRC_AT_RUN: r = s.at_running;
      `SRC_RAMPING: r = s.sp_ramping;
      `SRC_ALARM: r = s.alarm;
      `SRC_PV_ALARM: r = s.pv_alarm;
      `SRC_MODE_KEY: r = s.mode_key;
      `SRC_EVOUT1: r = s.event_out1;
      `SRC_CTRLOUT1: r = s.ctrl_out1;
      default: begin
        if (c >= `SRC_EV1 && c <= `SRC_EV5) begin
          r = s.internal_event[3'(c - `SRC_EV1)];
        end else if (c >= `SRC_COM1 && c <= `SRC_COM4) begin
          r = s.comm_input[2'(c - `SRC_COM1)];
        end else begin
          r = 1'b0; // Constant OFF and undefined codes
        end
      end
    endcase
    return r;
  endfunction

  logic a, b, c, d, f;
  // Per-input polarity then function
  always_comb begin
    a = pick(src_in, assign_in.sel_a) ^ polarity_in[0];
    b = pick(src_in, assign_in.sel_b) ^ polarity_in[1];
    c = pick(src_in, assign_in.sel_c) ^ polarity_in[2];
    d = pick(src_in, assign_in.sel_d) ^ polarity_in[3];
    case (func_in)
      3'd1: f = ((a & b) | (c & d)) ^ polarity_in[4];
      3'd2: f = ((a | b) & (c | d)) ^ polarity_in[4];
      3'd3: f = (a | b | c | d) ^ polarity_in[4];
      3'd4: f = (a & b & c & d) ^ polarity_in[4];
      default: begin
        if (INDEX < 2) begin
          f = src_in.digital_input[INDEX];
        end else begin
          f = 1'b0;
        end
      end
    endcase
    state_out = f;
  end
endmodule
`default_nettype wire

// ---- hw/pv_hold_tracker.sv ----
`include "contact_consts.svh"
`default_nettype none
module pv_hold_tracker #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic mclk_in, // Controller clock
  input wire logic reset_in, // Async reset, high
  input wire logic [WIDTH-1:0] pv_in, // Signed process value
  input wire logic pv_hold_in, // Freeze present value
  input wire logic max_hold_in, // Hold running maximum, raised by larger values
  input wire logic min_hold_in, // Hold running minimum, lowered by smaller values
  output logic [WIDTH-1:0] pv_out // Held or tracked value
);
  logic [WIDTH-1:0] val_q, val_d;
  logic [WIDTH-1:0] max_q, max_d, min_q, min_d;
  logic [WIDTH-1:0] out_q, out_d;
  // Track value, running max and min
  always_comb begin
    val_d = pv_hold_in ? val_q : pv_in;
    max_d = max_hold_in ? max_q : pv_in;
    if (max_hold_in && $signed(pv_in) > $signed(max_q)) begin
      max_d = pv_in;
    end
    min_d = min_hold_in ? min_q : pv_in;
    if (min_hold_in && $signed(pv_in) < $signed(min_q)) begin
      min_d = pv_in;
    end
    // Output priority max, min, then value
    if (max_hold_in) begin
      out_d = max_d;
    end else if (min_hold_in) begin
      out_d = min_d;
    end else begin
      out_d = val_d;
    end
  end
  // Registers
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      val_q <= '0;
      max_q <= '0;
      min_q <= '0;
      out_q <= '0;
    end else begin
      val_q <= val_d;
      max_q <= max_d;
      min_q <= min_d;
      out_q <= out_d;
    end
  end
  // Registered output, aligned with the decoded operations
  assign pv_out = out_q;
endmodule
`default_nettype wire

// ---- hw/internal_contact_logic.sv ----
`include "contact_consts.svh"
`default_nettype none
module internal_contact_logic
  import contact_pkg::*;
#(
  parameter int unsigned PV_WIDTH = 16
) (
  input wire logic mclk_in, // 100 MHz controller clock
  input wire logic reset_in, // Async reset, active high
  input wire logic wb_cyc_in, // Wishbone cycle
  input wire logic wb_stb_in, // Wishbone strobe
  input wire logic wb_we_in, // Wishbone write enable
  input wire logic [7:0] wb_adr_in, // Wishbone byte address
  input wire logic [3:0] wb_sel_in, // Wishbone byte selects
  input wire logic [31:0] wb_dat_in, // Wishbone write data
  output logic [31:0] wb_dat_out, // Wishbone read data
  output logic wb_ack_out, // Wishbone acknowledge
  input wire logic [1:0] digital_input_in, // Physical inputs, asynchronous
  input wire source_bits_t src_in, // Internal status, same clock
  input wire logic [PV_WIDTH-1:0] pv_in, // Process value
  output logic [PV_WIDTH-1:0] pv_out, // Held process value
  output actions_t actions_out // Decoded operations
);
  localparam int N = 3;
  // Configuration
  logic [4:0] op_q [N], op_d [N];
  logic [2:0] func_q [N], func_d [N];
  logic [2:0] tgt_q [N], tgt_d [N];
  assign_t asg_q [N], asg_d [N];
  logic [4:0] pol_q [N], pol_d [N];
  logic [31:0] rdat_d;
  logic ack_d;
  logic [5:0] di_pipe_q, di_pipe_d;
  logic [1:0] di_q, di_d;
  source_bits_t src;
  logic [N-1:0] state;
  actions_t act_d;

  // Decode byte address into contact index and slot
  function automatic logic [1:0] idx_of(input logic [7:0] a);
    return a[6:5];
  endfunction
  function automatic logic [7:0] slot_of(input logic [7:0] a);
    return {3'h0, a[4:0]};
  endfunction
  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // Three-stage sync, change taken when stages two and three agree
  always_comb begin
    di_pipe_d = {di_pipe_q[3:0], digital_input_in};
    di_d = di_q;
    for (int i = 0; i < 2; i++) begin
      if (di_pipe_q[2 + i] == di_pipe_q[4 + i]) begin
        di_d[i] = di_pipe_q[4 + i];
      end
    end
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      di_pipe_q <= 6'h00;
      di_q <= 2'h0;
    end else begin
      di_pipe_q <= di_pipe_d;
      di_q <= di_d;
    end
  end
  // Replace raw pins with synchronised copies
  always_comb begin
    src = src_in;
    src.digital_input = di_q;
  end

  // Contact evaluators
  for (genvar g = 0; g < N; g++) begin : g_contact
    contact_eval #(.INDEX(g)) u_eval (
      .src_in(src),
      .assign_in(asg_q[g]),
      .polarity_in(pol_q[g]),
      .func_in(func_q[g]),
      .state_out(state[g])
    );
  end

  // Register writes and read mux
  always_comb begin
    logic [1:0] ix;
    logic [7:0] sl;
    logic hit;
    logic [31:0] w;
    ix = idx_of(wb_adr_in);
    sl = slot_of(wb_adr_in);
    hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
    w = 32'h0000_0000;
    ack_d = hit;
    rdat_d = 32'h0000_0000;
    for (int i = 0; i < N; i++) begin
      op_d[i] = op_q[i];
      func_d[i] = func_q[i];
      tgt_d[i] = tgt_q[i];
      asg_d[i] = asg_q[i];
      pol_d[i] = pol_q[i];
    end
    if (wb_adr_in == `REG_SUMMARY) begin
      rdat_d = {29'h0, state};
    end else if (ix != 2'd3) begin
      case (sl)
        `REG_OP_TYPE: begin
          rdat_d = {27'h0, op_q[ix]};
          w = merge(rdat_d, wb_dat_in, wb_sel_in);
          if (hit && wb_we_in && w[4:0] <= `OP_MAX) begin
            op_d[ix] = w[4:0];
          end
        end
        `REG_FUNC_SEL: begin
          rdat_d = {29'h0, func_q[ix]};
          w = merge(rdat_d, wb_dat_in, wb_sel_in);
          if (hit && wb_we_in && w[2:0] <= `FUNC_MAX) begin
            func_d[ix] = w[2:0];
          end
        end
        `REG_TIMER_TGT: begin
          if (op_q[ix] == `OP_TIMER) begin
            rdat_d = {29'h0, tgt_q[ix]};
            w = merge(rdat_d, wb_dat_in, wb_sel_in);
            if (hit && wb_we_in && w[2:0] <= `TGT_MAX) begin
              tgt_d[ix] = w[2:0];
            end
          end
        end
        `REG_ASSIGN: begin
          rdat_d = {8'h0, asg_q[ix]};
          w = merge(rdat_d, wb_dat_in, wb_sel_in);
          if (hit && wb_we_in) begin
            asg_d[ix] = w[23:0];
          end
        end
        `REG_POLARITY: begin
          rdat_d = {27'h0, pol_q[ix]};
          w = merge(rdat_d, wb_dat_in, wb_sel_in);
          if (hit && wb_we_in) begin
            pol_d[ix] = w[4:0];
          end
        end
        `REG_STATUS: rdat_d = {31'h0, state[ix]};
        default: rdat_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < N; i++) begin
        op_q[i] <= `RST_OP_TYPE;
        func_q[i] <= `RST_FUNC_SEL;
        tgt_q[i] <= `RST_TIMER_TGT;
        pol_q[i] <= `RST_POLARITY;
      end
      asg_q[0] <= `RST_ASSIGN_C1;
      asg_q[1] <= `RST_ASSIGN_C2;
      asg_q[2] <= `RST_ASSIGN_C3;
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      for (int i = 0; i < N; i++) begin
        op_q[i] <= op_d[i];
        func_q[i] <= func_d[i];
        tgt_q[i] <= tgt_d[i];
        asg_q[i] <= asg_d[i];
        pol_q[i] <= pol_d[i];
      end
      wb_ack_out <= ack_d;
      if (ack_d) begin
        wb_dat_out <= rdat_d;
      end else begin
        wb_dat_out <= 32'h0000_0000;
      end
    end
  end

  // Operation decode from contact states
  always_comb begin
    logic [2:0] sum;
    sum = 3'h0;
    act_d = '0;
    for (int i = 0; i < N; i++) begin
      case (op_q[i])
        `OP_LSP_W1: begin
          if (state[i]) begin
            sum = sum | 3'h1;
          end
        end
        `OP_LSP_W2: begin
          if (state[i]) begin
            sum = sum | 3'h2;
          end
        end
        `OP_LSP_W4: begin
          if (state[i]) begin
            sum = sum | 3'h4;
          end
        end
        `OP_RUN_READY: begin
          act_d.ready = state[i];
        end
        `OP_AUTO_MANUAL: begin
          act_d.manual = state[i];
        end
        `OP_AUTO_TUNE: begin
          act_d.at_start = state[i];
        end
        `OP_SELF_TUNE: begin
          act_d.st_enable = state[i];
        end
        `OP_REVERSE: begin
          act_d.reverse_action = state[i];
        end
        `OP_RAMP: begin
          act_d.ramp_disable = state[i];
        end
        `OP_PV_HOLD: begin
          act_d.pv_hold = state[i];
        end
        `OP_MAX_HOLD: begin
          act_d.max_hold = state[i];
        end
        `OP_MIN_HOLD: begin
          act_d.min_hold = state[i];
        end
        `OP_TIMER: begin
          for (int e = 0; e < 5; e++) begin
            if (tgt_q[i] == 3'h0 || tgt_q[i] == 3'(e + 1)) begin
              act_d.timer_run[e] = state[i];
              act_d.timer_stop[e] = !state[i];
            end
          end
        end
        `OP_LATCH_REL: begin
          act_d.latch_release = state[i];
        end
        default: ;
      endcase
    end
    // Group eight needs the fourth bit
    act_d.lsp_group = {1'b0, sum} + 4'h1;
  end
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      actions_out <= '0;
    end else begin
      actions_out <= act_d;
    end
  end

  // Hold tracker for the process value
  pv_hold_tracker #(.WIDTH(PV_WIDTH)) u_hold (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .pv_in(pv_in),
    .pv_hold_in(act_d.pv_hold),
    .max_hold_in(act_d.max_hold),
    .min_hold_in(act_d.min_hold),
    .pv_out(pv_out)
  );
endmodule
`default_nettype wire

// ---- verif/field_source_model.sv ----
`default_nettype none
module field_source_model
  import contact_pkg::*;
(
  input wire logic mclk_in, // Controller clock
  input wire logic slow_in, // Late answer when high
  input wire logic [1:0] di_want_in, // Wanted contact levels
  input wire logic [4:0] ev_want_in, // Wanted event states
  input wire logic [3:0] com_want_in, // Wanted comm bits
  output logic [1:0] digital_input_out, // Physical inputs
  output source_bits_t src_out // Status bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] l0_q = '0;
  logic [10:0] l1_q = '0;
  logic [10:0] l2_q = '0;
  logic [10:0] now;
  // Delay line, one or three cycles
  always @(posedge mclk_in) begin
    l0_q <= {di_want_in, ev_want_in, com_want_in};
    l1_q <= l0_q;
    l2_q <= l1_q;
  end
  // Present the delayed levels
  always_comb begin
    now = slow_in ? l2_q : l0_q;
    src_out = '0;
    src_out.internal_event = now[8:4];
    src_out.comm_input = now[3:0];
    digital_input_out = now[10:9];
  end
endmodule
`default_nettype wire

// ---- verif/internal_contact_logic_checker.sv ----
`default_nettype none
module internal_contact_logic_checker
  import contact_pkg::*;
#(
  parameter int unsigned PV_WIDTH = 16
) (
  input wire logic mclk_in, // Clock
  input wire logic reset_in, // Async reset
  input wire logic wb_cyc_in, // Bus cycle
  input wire logic wb_stb_in, // Bus strobe
  input wire logic [31:0] wb_dat_out, // Read data
  input wire logic wb_ack_out, // Acknowledge
  input wire logic [PV_WIDTH-1:0] pv_in, // Process value
  input wire logic [PV_WIDTH-1:0] pv_out, // Held value
  input wire actions_t actions_out // Decoded operations
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  wire logic pvh = actions_out.pv_hold && !actions_out.max_hold && !actions_out.min_hold;
  wire logic noh = !actions_out.pv_hold && !actions_out.max_hold && !actions_out.min_hold;
  // Bus answer timing and idle data
  property p_ack_next; wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing");
  property p_ack_pulse; wb_ack_out |=> !wb_ack_out; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_dat_idle; !wb_ack_out |-> wb_dat_out == 32'h0; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data without ack");
  // Decoded operations
  property p_lsp_min; !$past(reset_in) |-> actions_out.lsp_group != 4'h0; endproperty
  a_lsp_min: assert property (p_lsp_min) else $error("group below one");
  property p_timer_excl; (actions_out.timer_run & actions_out.timer_stop) == 5'h0; endproperty
  a_timer_excl: assert property (p_timer_excl) else $error("timer run and stop");
  // Value path
  property p_hold_freeze; pvh [*3] |-> $stable(pv_out); endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("held value moved");
  property p_max_rise;
    actions_out.max_hold [*3] |-> $signed(pv_out) >= $signed($past(pv_out));
  endproperty
  a_max_rise: assert property (p_max_rise) else $error("maximum fell");
  property p_min_fall;
    (actions_out.min_hold && !actions_out.max_hold) [*3] |->
      $signed(pv_out) <= $signed($past(pv_out));
  endproperty
  a_min_fall: assert property (p_min_fall) else $error("minimum rose");
  property p_track; (noh && $stable(pv_in)) [*4] |-> pv_out == pv_in; endproperty
  a_track: assert property (p_track) else $error("value not tracked");
  c_lsp8: cover property (actions_out.lsp_group == 4'h8);
  c_timer: cover property (actions_out.timer_run != 5'h0);
  c_latch: cover property (actions_out.latch_release);
  c_max: cover property (actions_out.max_hold [*3]);
endmodule
bind internal_contact_logic internal_contact_logic_checker #(.PV_WIDTH(PV_WIDTH)) u_chk (
  .mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pv_in(pv_in), .pv_out(pv_out),
  .actions_out(actions_out));
`default_nettype wire

// ---- verif/tb_internal_contact_logic.sv ----
`default_nettype none
module tb_internal_contact_logic;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 0, reset_in = 1, cyc = 0, stb = 0, we = 0, slow = 0, ack;
  logic [7:0] adr = '0, lf = 8'h4C;
  logic [3:0] sel = '0, com = '0;
  logic [31:0] wdat = '0, rdat, rd;
  logic [15:0] pv = '0;
  logic [1:0] di = '0, di_pin;
  logic [4:0] ev = '0, pol[3];
  contact_pkg::source_bits_t srcb;
  contact_pkg::actions_t act;
  int error_cnt = 0, cmp_count = 0, ops[3], fn[3], tgt[3], asg[3][4];
  int codes[8] = '{0, 1, 2, 10, 14, 18, 19, 21};
  bit st[3];
  always #5 mclk_in = ~mclk_in;
  // Process value ramps with wrap
  always @(posedge mclk_in) if (rnd() < 8'h30) pv <= pv + 16'h3A5F;
  field_source_model src_m (.mclk_in(mclk_in), .slow_in(slow), .di_want_in(di),
    .ev_want_in(ev), .com_want_in(com), .digital_input_out(di_pin), .src_out(srcb));
  internal_contact_logic dut (.mclk_in(mclk_in), .reset_in(reset_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .digital_input_in(di_pin), .src_in(srcb),
    .pv_in(pv), .pv_out(), .actions_out(act));
  function automatic logic [7:0] rnd();
    lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
    return lf;
  endfunction
  function automatic bit srcv(int c);
    if (c == 1) return 1;
    if (c == 2 || c == 3) return di[c-2];
    if (c >= 10 && c <= 14) return ev[c-10];
    if (c >= 18 && c <= 21) return com[c-18];
    return 0;
  endfunction
  // Contact state from its setup
  function automatic bit cstate(int k);
    logic [3:0] x;
    if (fn[k] == 0) return k < 2 ? di[k] : 1'b0;
    for (int i = 0; i < 4; i++) x[i] = srcv(asg[k][i]) ^ pol[k][i];
    case (fn[k])
      1: return ((x[0] & x[1]) | (x[2] & x[3])) ^ pol[k][4];
      2: return ((x[0] | x[1]) & (x[2] | x[3])) ^ pol[k][4];
      3: return (|x) ^ pol[k][4];
      default: return (&x) ^ pol[k][4];
    endcase
  endfunction
  // Operations from types and states
  function automatic contact_pkg::actions_t exp_act();
    contact_pkg::actions_t e;
    int g;
    logic [4:0] m;
    e = '0;
    g = 1;
    for (int k = 0; k < 3; k++) begin
      m = tgt[k] == 0 ? 5'h1F : 5'h01 << (tgt[k] - 1);
      case (ops[k])
        1, 2, 3: g += st[k] << (ops[k] - 1);
        7: e.ready = st[k];
        8: e.manual = st[k];
        10: e.at_start = st[k];
        11: e.st_enable = st[k];
        12: e.reverse_action = st[k];
        13: e.ramp_disable = st[k];
        14: e.pv_hold = st[k];
        15: e.max_hold = st[k];
        16: e.min_hold = st[k];
        17: if (st[k]) e.timer_run = m; else e.timer_stop = m;
        18: e.latch_release = st[k];
        default: ;
      endcase
    end
    e.lsp_group = 4'(g);
    return e;
  endfunction
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Classic single Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk_in);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
    rd = rdat;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic wr(int k, int off, int v);
    wb(1'b1, 8'(k * 32 + off), 32'(v));
  endtask
  task automatic rdc(int k, int off, int e);
    wb(1'b0, 8'(k * 32 + off), 32'h0);
    cmp(rd, 32'(e));
  endtask
  // Drive sources, settle, compare contact states, summary and operations
  task automatic chk(string nm, logic [1:0] d, logic [4:0] e, logic [3:0] c, logic s);
    @(posedge mclk_in);
    di <= d;
    ev <= e;
    com <= c;
    slow <= s;
    repeat (10) @(posedge mclk_in);
    for (int k = 0; k < 3; k++) st[k] = cstate(k);
    for (int k = 0; k < 3; k++) rdc(k, 8'h14, st[k]);
    rdc(3, 0, {st[2], st[1], st[0]});
    cmp(32'(act), 32'(exp_act()));
    $display("test %s done", nm);
  endtask
  initial begin
    logic [31:0] v;
    for (int k = 0; k < 3; k++) begin
      pol[k] = '0;
      asg[k] = '{k + 2, 0, 0, 0};
    end
    repeat (5) @(posedge mclk_in);
    reset_in <= 0;
    for (int k = 0; k < 3; k++)
      for (int o = 0; o < 5; o++) rdc(k, o * 4, o == 3 ? k + 2 : 0);
    rdc(3, 8'h1C, 0);
    for (int n = 0; n < 4; n++) chk("default", 2'(n), 5'h0, 4'h0, n[0]);
    for (int n = 0; n < 24; n++) begin
      v = {rnd(), rnd(), rnd(), rnd()};
      for (int i = 0; i < 4; i++) asg[0][i] = codes[v[3*i +: 3]];
      fn[0] = 1 + n % 4;
      pol[0] = v[16:12];
      wr(0, 8'h0C, {asg[0][3][5:0], asg[0][2][5:0], asg[0][1][5:0], asg[0][0][5:0]});
      wr(0, 8'h04, fn[0]);
      wr(0, 8'h04, 5);
      wr(0, 8'h10, pol[0]);
      chk("function", v[18:17], v[23:19], v[27:24], v[28]);
      rdc(0, 8'h04, fn[0]);
    end
    fn[0] = 0;
    wr(0, 8'h04, 0);
    for (int o = 0; o <= 20; o++) begin
      ops[0] = o;
      wr(0, 0, o);
      for (int s = 0; s < 2; s++) chk("optype", 2'(s), 5'h0, 4'h0, 1'b0);
    end
    ops = '{1, 2, 3};
    asg[2][0] = 18;
    fn[2] = 3;
    for (int k = 0; k < 3; k++) wr(k, 0, ops[k]);
    wr(2, 8'h0C, 18);
    wr(2, 8'h04, 3);
    for (int g = 0; g < 8; g++) chk("weights", 2'(g), 5'h0, {3'h0, g[2]}, g[0]);
    ops[0] = 0;
    wr(0, 0, 0);
    wr(0, 8'h08, 3);
    rdc(0, 8'h08, 0);
    ops[0] = 17;
    tgt[0] = 3;
    wr(0, 0, 17);
    wr(0, 8'h08, 3);
    wr(0, 8'h08, 6);
    rdc(0, 8'h08, 3);
    for (int s = 0; s < 2; s++) chk("timer", 2'(s), 5'h0, 4'h0, 1'b1);
    // Mid-run reset returns every setting to its default
    @(posedge mclk_in);
    reset_in <= 1;
    repeat (2) @(posedge mclk_in);
    reset_in <= 0;
    for (int k = 0; k < 3; k++) begin
      ops[k] = 0;
      tgt[k] = 0;
      fn[k] = 0;
      pol[k] = '0;
      asg[k] = '{k + 2, 0, 0, 0};
    end
    rdc(0, 0, 0);
    rdc(2, 8'h0C, 4);
    chk("reset", 2'h2, 5'h0, 4'h0, 1'b0);
    give_verdict();
  end
endmodule
`default_nettype wire
